/* File: design/dao_pkg.sv */
// Purpose: Shared constants and types for the dual converter output control
// Assumes: mclk at 250 MHz; sample clocks and control pins are asynchronous
// Notes: Register offsets are byte addresses on a 32-bit APB slave
package dao_pkg;
  // Word widths and conversion range
  localparam int DAO_WORD_W = 10;
  localparam int DAO_RAW_W = 12;
  localparam logic signed [11:0] DAO_RAW_POS_END = 12'h1FF;
  localparam logic signed [11:0] DAO_RAW_NEG_END = 12'hE00;
  localparam logic [9:0] DAO_SIGN_FLIP = 10'h200;

  // Four-level format pin, as coded by the level sensor
  localparam logic [1:0] DAO_LVL_GND = 2'h0;
  localparam logic [1:0] DAO_LVL_THIRD = 2'h1;
  localparam logic [1:0] DAO_LVL_TWO_THIRD = 2'h2;
  localparam logic [1:0] DAO_LVL_VDD = 2'h3;

  // Register offsets
  localparam logic [11:0] DAO_CTRL_OFS = 12'h000;
  localparam logic [11:0] DAO_STATUS_OFS = 12'h004;
  localparam logic [11:0] DAO_SAMPLE_A_OFS = 12'h008;
  localparam logic [11:0] DAO_SAMPLE_B_OFS = 12'h00C;

  // Field positions and reset values
  localparam logic [31:0] DAO_CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] DAO_CTRL_MASK = 32'h0000_0003;
  localparam int DAO_CTRL_DRV_LSB = 0;
  localparam int DAO_ST_PWR_LSB = 0;
  localparam int DAO_ST_READY_LSB = 4;
  localparam int DAO_ST_LOCK_LSB = 6;
  localparam int DAO_ST_TWOS_BIT = 8;
  localparam int DAO_ST_STAB_BIT = 9;
  localparam int DAO_ST_SWAP_BIT = 10;
  localparam int DAO_SMP_FLAG_BIT = 10;

  // Timing
  localparam int DAO_MCLK_MHZ = 250;
  localparam int DAO_MCLK_NS = 4;
  localparam int DAO_SLEEP_WAKE_MS = 2;
  localparam int DAO_SLEEP_WAKE_CLKS = DAO_SLEEP_WAKE_MS * 1000 * DAO_MCLK_MHZ;
  localparam int DAO_NAP_WAKE_CYC = 100;
  localparam int DAO_RELOCK_CYC = 100;
  localparam int DAO_CLK_STOP_NS = 2000;
  localparam int DAO_CLK_STOP_CLKS = (DAO_CLK_STOP_NS + DAO_MCLK_NS - 1) / DAO_MCLK_NS;
  localparam int DAO_PIPE_DEPTH = 5;

  // Per-channel power state
  typedef enum logic [1:0] {
    DAO_PWR_RUN,
    DAO_PWR_NAP,
    DAO_PWR_SLEEP,
    DAO_PWR_WAKE
  } dao_pwr_t;
endpackage

/* File: design/dao_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Inputs are slow levels or clocks well below mclk
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module dao_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import dao_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } dao_sync_st_t;

  dao_sync_st_t st_r, st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("dao_sync needs WIDTH of at least one");
  end

  // Shift through both stages
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.held = st_r.meta;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.held;
endmodule

/* File: design/dao_chan.sv */
// Purpose: Output coding and pipeline for one converter channel
// Assumes: sample_en is a one-cycle pulse per rising sample clock edge
// Notes: Pipeline only advances on sample_en, so latency is in sample clocks
`timescale 1ns/1ps
module dao_chan #(
  parameter int PIPE_DEPTH = dao_pkg::DAO_PIPE_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Conversion input
  input wire logic sample_en,
  input wire logic signed [dao_pkg::DAO_RAW_W-1:0] conv_value,
  input wire logic twos_fmt,
  // Coded output
  output logic [dao_pkg::DAO_WORD_W-1:0] word_r,
  output logic flag_r
);
  import dao_pkg::*;

  typedef struct packed {
    logic [PIPE_DEPTH-1:0][DAO_WORD_W-1:0] word;
    logic [PIPE_DEPTH-1:0] flag;
  } dao_chst_t;

  dao_chst_t st_r, st_nxt;

  if (PIPE_DEPTH < 1) begin : g_bad_depth
    $error("dao_chan needs PIPE_DEPTH of at least one");
  end

  // Clamp to the range ends and flag anything beyond them
  function automatic logic [DAO_WORD_W:0] dao_code(input logic signed [DAO_RAW_W-1:0] v,
                                                   input logic twos);
    logic [DAO_WORD_W-1:0] sat;
    logic over;
    sat = v[DAO_WORD_W-1:0];
    over = 1'b0;
    if (v > DAO_RAW_POS_END) begin
      sat = DAO_RAW_POS_END[DAO_WORD_W-1:0];
      over = 1'b1;
    end else if (v < DAO_RAW_NEG_END) begin
      sat = DAO_RAW_NEG_END[DAO_WORD_W-1:0];
      over = 1'b1;
    end
    // Offset binary is two's complement with the sign bit turned round
    if (!twos) begin
      sat = sat ^ DAO_SIGN_FLIP;
    end
    return {over, sat};
  endfunction

  // Code on each sample edge and shift the pipeline
  always_comb begin
    st_nxt = st_r;
    if (sample_en) begin
      {st_nxt.flag[0], st_nxt.word[0]} = dao_code(conv_value, twos_fmt);
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        st_nxt.word[i] = st_r.word[i-1];
        st_nxt.flag[i] = st_r.flag[i-1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word_r = st_r.word[PIPE_DEPTH-1];
  assign flag_r = st_r.flag[PIPE_DEPTH-1];

  // Checks on the first pipeline stage
  a_offset_mid: assert property (@(posedge mclk) disable iff (sys_rst)
    sample_en && !twos_fmt && conv_value == 0 |=> st_r.word[0] == 10'h200 && !st_r.flag[0])
    else $error("offset binary zero code wrong");
  a_twos_ends: assert property (@(posedge mclk) disable iff (sys_rst)
    sample_en && twos_fmt && conv_value == DAO_RAW_NEG_END |=> st_r.word[0] == 10'h200)
    else $error("two's complement negative end wrong");
  a_over_clamp: assert property (@(posedge mclk) disable iff (sys_rst)
    sample_en && conv_value > DAO_RAW_POS_END |=>
    st_r.flag[0] && st_r.word[0] == ($past(twos_fmt) ? 10'h1FF : 10'h3FF))
    else $error("overrange not clamped or flagged");
  a_in_range: assert property (@(posedge mclk) disable iff (sys_rst)
    sample_en && conv_value <= DAO_RAW_POS_END && conv_value >= DAO_RAW_NEG_END
    |=> !st_r.flag[0])
    else $error("flag set for in-range input");
endmodule

/* File: design/dao_top.sv */
// Purpose: Output control of a dual 10-bit converter: coding, enables, power, swap
// Assumes: Pins are asynchronous to mclk; conversion values come from mclk logic
// Notes: APB slave answers with one wait state; bus pins are out plus enable
// Operation
// - Offset binary: all ones top, one then zeros at zero, all zeros bottom.
// - Two's complement: zero then ones top, zeros at zero, one then zeros bottom.
// - Beyond range clamp word to end code and raise flag; flag low in range.
// - Raised flag means the sample was above or below the range.
// - Format pin levels select coding and stabilizer in four combinations.
// - Ground or one-third level gives offset binary words.
// - Two-thirds or full level gives two's complement words.
// - Channel enable high puts its data and flag outputs in high impedance.
// - Each channel has its own enable acting only on its own bus.
// - Shutdown low means normal operation of that channel.
// - Shutdown and enable high give sleep; long recovery after leaving.
// - Shutdown high and enable low give nap; recovery about 100 sample clocks.
// - In sleep or nap all outputs of the channel are high impedance.
// - Shutdown, sleep, nap and enable are independent per channel.
// - Swap select high: channel A on bus A, channel B on bus B.
// - Swap select low: channel A on bus B, channel B on bus A.
// - Stabilizer on: rising edge sampling, about 100 cycles relock after clock stop.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dao_top #(
  parameter int SLEEP_WAKE_CLKS = dao_pkg::DAO_SLEEP_WAKE_CLKS,
  parameter int CLK_STOP_CLKS = dao_pkg::DAO_CLK_STOP_CLKS,
  parameter int PIPE_DEPTH = dao_pkg::DAO_PIPE_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion results from the converter core
  input wire logic [dao_pkg::DAO_RAW_W-1:0] conv_value_a,
  input wire logic [dao_pkg::DAO_RAW_W-1:0] conv_value_b,
  // Control pins
  input wire logic sample_clock_a,
  input wire logic sample_clock_b,
  input wire logic bus_swap_sel,
  input wire logic [1:0] format_level,
  input wire logic chan_a_power_down,
  input wire logic chan_b_power_down,
  input wire logic chan_a_drive_enable_n,
  input wire logic chan_b_drive_enable_n,
  // Output bus A
  output logic [dao_pkg::DAO_WORD_W-1:0] bus_a_word,
  output logic overrange_flag_bus_a,
  output logic bus_a_oe,
  // Output bus B
  output logic [dao_pkg::DAO_WORD_W-1:0] bus_b_word,
  output logic overrange_flag_bus_b,
  output logic bus_b_oe
);
  import dao_pkg::*;

  localparam int WAKE_W = $clog2(SLEEP_WAKE_CLKS + 1);
  localparam int IDLE_W = $clog2(CLK_STOP_CLKS + 1);
  localparam int LOCK_W = $clog2(DAO_RELOCK_CYC + 1);
  localparam logic [WAKE_W-1:0] SLEEP_LOAD = WAKE_W'(SLEEP_WAKE_CLKS);
  localparam logic [WAKE_W-1:0] NAP_LOAD = WAKE_W'(DAO_NAP_WAKE_CYC);
  localparam logic [IDLE_W-1:0] STOP_MAX = IDLE_W'(CLK_STOP_CLKS);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DAO_RELOCK_CYC - 1);

  if (SLEEP_WAKE_CLKS < DAO_NAP_WAKE_CYC || CLK_STOP_CLKS < 2) begin : g_bad_cfg
    $error("dao_top wake or stop count too small");
  end

  typedef struct packed {
    dao_pwr_t pwr;
    logic from_sleep;
    logic [WAKE_W-1:0] wake_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic locked;
    logic [LOCK_W-1:0] lock_cnt;
    logic sclk_d;
  } dao_ch_t;

  typedef struct packed {
    dao_ch_t [1:0] ch;
    logic [1:0][DAO_WORD_W-1:0] bus_word;
    logic [1:0] bus_flag;
    logic [1:0] bus_oe;
    logic [31:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dao_top_t;

  dao_top_t st_r, st_nxt;

  logic [1:0] sclk_s;
  logic [1:0] pd_s;
  logic [1:0] oen_s;
  logic swap_s;
  logic [1:0] fmt_s;
  logic twos;
  logic stab;
  logic [1:0] smp_en;
  logic [1:0] ready;
  logic [1:0][DAO_WORD_W-1:0] ch_word;
  logic [1:0] ch_flag;
  logic [1:0][DAO_RAW_W-1:0] conv_val;

  // Pins cross into mclk; the sample clocks are sampled like any level
  dao_sync #(.WIDTH(9)) u_pins (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({sample_clock_b, sample_clock_a, chan_b_power_down, chan_a_power_down,
               chan_b_drive_enable_n, chan_a_drive_enable_n, bus_swap_sel, format_level}),
    .sync_out({sclk_s, pd_s, oen_s, swap_s, fmt_s})
  );

  // Format pin decode; middle levels switch the stabilizer on
  assign twos = fmt_s[1];
  assign stab = fmt_s == DAO_LVL_THIRD || fmt_s == DAO_LVL_TWO_THIRD;
  assign conv_val = {conv_value_b, conv_value_a};

  // Drive allowed only when enabled, awake and not held off by software
  function automatic logic dao_drive(input dao_pwr_t pwr, input logic pd, input logic oen,
                                     input logic sw_en);
    return !oen && !pd && sw_en && pwr != DAO_PWR_NAP && pwr != DAO_PWR_SLEEP;
  endfunction

  // Per channel: edge detect, coding pipeline, readiness
  for (genvar g = 0; g < 2; g++) begin : g_ch
    // Rising edge only; the falling edge of the sample clock is never used
    assign smp_en[g] = sclk_s[g] & ~st_r.ch[g].sclk_d;
    assign ready[g] = st_r.ch[g].pwr == DAO_PWR_RUN && (st_r.ch[g].locked || !stab);

    dao_chan #(.PIPE_DEPTH(PIPE_DEPTH)) u_chan (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .sample_en(smp_en[g]),
      .conv_value(conv_val[g]),
      .twos_fmt(twos),
      .word_r(ch_word[g]),
      .flag_r(ch_flag[g])
    );

    a_enable_hiz: assert property (@(posedge mclk) disable iff (sys_rst)
      oen_s[g] |=> !st_r.bus_oe[g])
      else $error("bus driven while its enable is high");
    a_pd_hiz: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r.ch[g].pwr == DAO_PWR_NAP || st_r.ch[g].pwr == DAO_PWR_SLEEP |-> !st_r.bus_oe[g])
      else $error("bus driven in nap or sleep");
    a_sleep_entry: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r.ch[g].pwr == DAO_PWR_RUN && pd_s[g] && oen_s[g] |=>
      st_r.ch[g].pwr == DAO_PWR_SLEEP)
      else $error("sleep not entered");
    a_nap_entry: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r.ch[g].pwr == DAO_PWR_RUN && pd_s[g] && !oen_s[g] |=> st_r.ch[g].pwr == DAO_PWR_NAP)
      else $error("nap not entered");
    a_nap_recover: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r.ch[g].pwr == DAO_PWR_NAP && !st_r.ch[g].from_sleep && !pd_s[g] |=>
      st_r.ch[g].pwr == DAO_PWR_WAKE && st_r.ch[g].wake_cnt == 100)
      else $error("nap recovery count wrong");
    a_run_stays: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r.ch[g].pwr == DAO_PWR_RUN && !pd_s[g] |=> st_r.ch[g].pwr == DAO_PWR_RUN)
      else $error("channel left normal operation");
    a_relock_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      stab && !st_r.ch[g].locked |-> !ready[g])
      else $error("ready before stabilizer relock");
  end

  // Bus swap checks: bus A carries channel A when the select is high
  a_swap_high: assert property (@(posedge mclk) disable iff (sys_rst)
    swap_s |=> bus_a_word == $past(ch_word[0]) && overrange_flag_bus_b == $past(ch_flag[1]))
    else $error("straight bus mapping wrong");
  a_swap_low: assert property (@(posedge mclk) disable iff (sys_rst)
    !swap_s |=> bus_b_word == $past(ch_word[0]) && overrange_flag_bus_a == $past(ch_flag[1]))
    else $error("swapped bus mapping wrong");

  // Next-state logic for power, lock, buses and the register slave
  always_comb begin
    logic [31:0] status;
    logic tick;
    status = '0;
    tick = 1'b0;
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;

    for (int i = 0; i < 2; i++) begin
      st_nxt.ch[i].sclk_d = sclk_s[i];

      // Clock stop watchdog; a stopped clock forces a fresh relock
      if (smp_en[i]) begin
        st_nxt.ch[i].idle_cnt = '0;
      end else if (st_r.ch[i].idle_cnt != STOP_MAX) begin
        st_nxt.ch[i].idle_cnt = st_r.ch[i].idle_cnt + 1'b1;
      end
      if (st_r.ch[i].idle_cnt == STOP_MAX) begin
        st_nxt.ch[i].locked = 1'b0;
        st_nxt.ch[i].lock_cnt = '0;
      end else if (!st_r.ch[i].locked && smp_en[i]) begin
        if (st_r.ch[i].lock_cnt == LOCK_LAST) begin
          st_nxt.ch[i].locked = 1'b1;
        end else begin
          st_nxt.ch[i].lock_cnt = st_r.ch[i].lock_cnt + 1'b1;
        end
      end

      // Power state; each channel sees only its own shutdown and enable
      tick = st_r.ch[i].from_sleep | smp_en[i];
      case (st_r.ch[i].pwr)
        DAO_PWR_RUN, DAO_PWR_WAKE: begin
          if (pd_s[i]) begin
            st_nxt.ch[i].pwr = oen_s[i] ? DAO_PWR_SLEEP : DAO_PWR_NAP;
            st_nxt.ch[i].from_sleep = oen_s[i];
          end else if (st_r.ch[i].pwr == DAO_PWR_WAKE && tick) begin
            st_nxt.ch[i].wake_cnt = st_r.ch[i].wake_cnt - 1'b1;
            if (st_r.ch[i].wake_cnt <= 1) begin
              // Back in normal operation; a later nap gets the short recovery
              st_nxt.ch[i].pwr = DAO_PWR_RUN;
              st_nxt.ch[i].from_sleep = 1'b0;
            end
          end
        end
        DAO_PWR_NAP, DAO_PWR_SLEEP: begin
          // Once the reference went down the long recovery applies
          if (!pd_s[i]) begin
            st_nxt.ch[i].pwr = DAO_PWR_WAKE;
            st_nxt.ch[i].wake_cnt = st_r.ch[i].from_sleep ? SLEEP_LOAD : NAP_LOAD;
          end else if (oen_s[i]) begin
            st_nxt.ch[i].pwr = DAO_PWR_SLEEP;
            st_nxt.ch[i].from_sleep = 1'b1;
          end else begin
            st_nxt.ch[i].pwr = DAO_PWR_NAP;
          end
        end
        default: begin
          st_nxt.ch[i].pwr = DAO_PWR_RUN;
        end
      endcase

      // Physical bus i follows the enable and shutdown of channel i
      st_nxt.bus_oe[i] = dao_drive(st_r.ch[i].pwr, pd_s[i], oen_s[i],
                                   st_r.ctrl[DAO_CTRL_DRV_LSB + i]);

      status[DAO_ST_PWR_LSB + 2 * i +: 2] = st_r.ch[i].pwr;
      status[DAO_ST_READY_LSB + i] = ready[i];
      status[DAO_ST_LOCK_LSB + i] = st_r.ch[i].locked;
    end
    status[DAO_ST_TWOS_BIT] = twos;
    status[DAO_ST_STAB_BIT] = stab;
    status[DAO_ST_SWAP_BIT] = swap_s;

    // Swap select high keeps channels straight, low crosses them
    st_nxt.bus_word[0] = swap_s ? ch_word[0] : ch_word[1];
    st_nxt.bus_flag[0] = swap_s ? ch_flag[0] : ch_flag[1];
    st_nxt.bus_word[1] = swap_s ? ch_word[1] : ch_word[0];
    st_nxt.bus_flag[1] = swap_s ? ch_flag[1] : ch_flag[0];

    // One wait state lets read data come out of a register
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      case (paddr)
        DAO_CTRL_OFS: st_nxt.prdata = st_r.ctrl;
        DAO_STATUS_OFS: st_nxt.prdata = status;
        DAO_SAMPLE_A_OFS: begin
          st_nxt.prdata = '0;
          st_nxt.prdata[DAO_SMP_FLAG_BIT:0] = {ch_flag[0], ch_word[0]};
        end
        DAO_SAMPLE_B_OFS: begin
          st_nxt.prdata = '0;
          st_nxt.prdata[DAO_SMP_FLAG_BIT:0] = {ch_flag[1], ch_word[1]};
        end
        default: begin
          st_nxt.prdata = '0;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // Write lands on the edge that completes the access
    if (psel && penable && st_r.pready && pwrite && paddr == DAO_CTRL_OFS) begin
      st_nxt.ctrl = pwdata & DAO_CTRL_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.ctrl <= DAO_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign bus_a_word = st_r.bus_word[0];
  assign overrange_flag_bus_a = st_r.bus_flag[0];
  assign bus_a_oe = st_r.bus_oe[0];
  assign bus_b_word = st_r.bus_word[1];
  assign overrange_flag_bus_b = st_r.bus_flag[1];
  assign bus_b_oe = st_r.bus_oe[1];

  // Software hold-off reaches the pins one cycle after the write
  a_sw_holdoff: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_r.ctrl[DAO_CTRL_DRV_LSB] |=> !bus_a_oe)
    else $error("bus A driven while held off");
endmodule

/* File: tb/dao_capture.sv */
// Purpose: Capture-side model: makes the sample clock and latches both output buses
// Assumes: Sample clock half period of HALF mclk cycles, HALF at least 2
// Notes: A released bus is never latched; its capture keeps the last value taken while it was driven
`timescale 1ns/1ps
module dao_capture #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic mclk,
  // Sample clock control
  input wire logic run,
  output logic smp_clk,
  // Bus A
  input wire logic [dao_pkg::DAO_WORD_W-1:0] wa,
  input wire logic fl_a,
  input wire logic oe_a,
  // Bus B
  input wire logic [dao_pkg::DAO_WORD_W-1:0] wb,
  input wire logic fl_b,
  input wire logic oe_b,
  // Latched words, flag on top
  output logic [dao_pkg::DAO_WORD_W:0] cap_a,
  output logic [dao_pkg::DAO_WORD_W:0] cap_b
);
  int cnt = 0;
  initial smp_clk = 1'b0;
  initial cap_a = '0;
  initial cap_b = '0;
  // Clock stands low while stopped, so no stray edge reaches the pins
  always @(posedge mclk) begin
    if (!run) begin
      cnt <= 0;
      smp_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      smp_clk <= !smp_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Latch at each rising sample edge, only from a bus that is driven
  always @(posedge mclk) begin
    if (run && !smp_clk && cnt == HALF - 1) begin
      if (oe_a) cap_a <= {fl_a, wa};
      if (oe_b) cap_b <= {fl_b, wb};
    end
  end
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the dual converter output control
// Assumes: Shortened wake count and pipeline depth; shared sample clock
// Notes: Expected codes are worked out here from the range ends
`timescale 1ns/1ps
module tb;
  import dao_pkg::*;
  localparam int PIPE = 2;
  localparam int WAKE = 200;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err, smp_clk;
  logic swap, pd_a, pd_b, en_n_a, en_n_b, fl_a, fl_b, oe_a, oe_b, run_clk;
  logic [11:0] paddr, conv_a, conv_b;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] lvl;
  logic [9:0] wa, wb;
  logic [10:0] cap_a, cap_b, ea, eb;
  logic [11:0] vals [7] = '{12'h1FF, 12'h000, 12'hE00, 12'h200, 12'hDFF, 12'h001, 12'hFFF};
  int miscompares = 0;
  int n_tests = 0;

  dao_top #(.SLEEP_WAKE_CLKS(WAKE), .CLK_STOP_CLKS(50), .PIPE_DEPTH(PIPE)) i_dao_top (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_value_a(conv_a), .conv_value_b(conv_b), .sample_clock_a(smp_clk),
    .sample_clock_b(smp_clk), .bus_swap_sel(swap), .format_level(lvl),
    .chan_a_power_down(pd_a), .chan_b_power_down(pd_b), .chan_a_drive_enable_n(en_n_a),
    .chan_b_drive_enable_n(en_n_b), .bus_a_word(wa), .overrange_flag_bus_a(fl_a),
    .bus_a_oe(oe_a), .bus_b_word(wb), .overrange_flag_bus_b(fl_b), .bus_b_oe(oe_b));
  dao_capture i_dao_capture (.mclk(mclk), .run(run_clk), .smp_clk(smp_clk), .wa(wa),
    .fl_a(fl_a), .oe_a(oe_a), .wb(wb), .fl_b(fl_b), .oe_b(oe_b), .cap_a(cap_a),
    .cap_b(cap_b));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 16) begin
      miscompares++;
      $display("unexpected at %0t ns: no bus answer", $time);
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait n sample edges, then let the bus settle
  task edges(input int n);
    repeat (n) @(posedge smp_clk);
    repeat (6) @(posedge mclk);
  endtask

  // Clamp beyond either end; offset binary is the sign bit inverted
  function automatic logic [10:0] code(input logic [11:0] raw, input logic twos);
    logic [9:0] c;
    logic hi;
    logic lo;
    hi = $signed(raw) > DAO_RAW_POS_END;
    lo = $signed(raw) < DAO_RAW_NEG_END;
    c = hi ? 10'h1FF : (lo ? 10'h200 : raw[9:0]);
    return {hi | lo, twos ? c : c ^ 10'h200};
  endfunction

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t ns: run too long", $time);
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, conv_a, conv_b, lvl} = '0;
    {swap, pd_a, pd_b, en_n_a, en_n_b} = 5'b10000;
    run_clk = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // Reset value, then an unmapped address is refused
    apb(1'b0, DAO_CTRL_OFS, '0);
    chk(rd, DAO_CTRL_RST);
    apb(1'b0, 12'h010, '0);
    chk({err, rd[0]}, 2'b10);
    // Every format level against every code class, both channels
    for (int l = 0; l < 4; l++) begin
      for (int k = 0; k < 7; k++) begin
        lvl <= 2'(l);
        conv_a <= vals[k];
        conv_b <= vals[(k + 3) % 7];
        edges(PIPE + 2);
        ea = code(vals[k], l >= 2);
        eb = code(vals[(k + 3) % 7], l >= 2);
        chk({fl_a, wa}, ea);
        chk({fl_b, wb}, eb);
        chk(cap_a, ea);
        chk(cap_b, eb);
      end
      apb(1'b0, DAO_STATUS_OFS, '0);
      chk(rd[DAO_ST_STAB_BIT:DAO_ST_TWOS_BIT], {l == 1 || l == 2, l >= 2});
    end
    // Crossed buses without any sample edge needed
    swap <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({fl_a, wa, fl_b, wb}, {eb, ea});
    swap <= 1'b1;
    // Enables change only while idle; A alone floats bus A
    en_n_a <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({oe_a, oe_b}, 2'b01);
    // Sleep on A, nap on B at once
    pd_a <= 1'b1;
    pd_b <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[3:0], 4'h6);
    chk({oe_a, oe_b}, 2'b00);
    // Nap recovery is counted in sample edges
    pd_b <= 1'b0;
    edges(90);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[3:2], 2'h3);
    edges(15);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[3:0], 4'h2);
    // Sleep recovery is counted in mclk cycles
    en_n_a <= 1'b0;
    pd_a <= 1'b0;
    repeat (WAKE / 2) @(posedge mclk);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[1:0], 2'h3);
    repeat (WAKE) @(posedge mclk);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk({rd[1:0], oe_a, oe_b}, 4'b0011);
    // Software drive allow of B cleared floats bus B only
    apb(1'b1, DAO_CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    chk({oe_a, oe_b}, 2'b10);
    apb(1'b0, DAO_CTRL_OFS, '0);
    chk(rd, 32'h0000_0001);
    // Stabilizer on: locked and ready, then a stopped clock drops the lock
    lvl <= 2'h1;
    edges(2);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[7:4], 4'hF);
    run_clk <= 1'b0;
    repeat (60) @(posedge mclk);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[7:4], 4'h0);
    // First edge after the stop only restarts the count; 100 more relock
    run_clk <= 1'b1;
    edges(102);
    apb(1'b0, DAO_STATUS_OFS, '0);
    chk(rd[7:4], 4'hF);
    give_verdict();
  end
endmodule
